// file: rtl/psru_bit_shift.sv
// One-place word shifter with inserted and ejected bit
`timescale 1ns/1ps
module psru_bit_shift
  import psru_pkg::*;
(
  // Operand
  input  wire logic [PSRU_WORD_W-1:0] word_i,
  input  wire logic                   left_i,
  input  wire logic                   ins_i,
  // Result
  output logic      [PSRU_WORD_W-1:0] word_o,
  output logic                        out_o
);

  // ==========================================================================
  // Shift toward MSB or LSB
  always_comb begin
    if (left_i) begin
      word_o = {word_i[PSRU_MSB-1:PSRU_LSB], ins_i};
      out_o  = word_i[PSRU_MSB];
    end else begin
      word_o = {ins_i, word_i[PSRU_MSB:PSRU_LSB+1]};
      out_o  = word_i[PSRU_LSB];
    end
  end

endmodule : psru_bit_shift

// file: rtl/psru_pkg.sv
// Shared constants, types and helpers for the shift and rotate unit
package psru_pkg;

  // ==========================================================================
  // Word layout
  localparam int          PSRU_WORD_W    = 16;
  localparam int          PSRU_MSB       = 15;
  localparam int          PSRU_LSB       = 0;
  localparam int          PSRU_DIGITS    = 4;
  localparam logic [15:0] PSRU_WORD_ZERO = 16'h0000;

  // ==========================================================================
  // Control word of the reversible shift
  localparam int PSRU_RV_DIR_BIT   = 12;
  localparam int PSRU_RV_INS_BIT   = 13;
  localparam int PSRU_RV_PULSE_BIT = 14;
  localparam int PSRU_RV_CLR_BIT   = 15;

  // ==========================================================================
  // Address map: area code above word offset
  localparam int         PSRU_AREA_W  = 3;
  localparam int         PSRU_OFF_W   = 8;
  localparam int         PSRU_AW      = PSRU_AREA_W + PSRU_OFF_W;
  localparam logic [2:0] PSRU_DM_AREA = 3'h3;

  // ==========================================================================
  // Operations
  typedef enum logic [2:0] {
    OP_EDGE_SHIFT,
    OP_REV_SHIFT,
    OP_ASL,
    OP_ASR,
    OP_ROL
  } psru_op_e;

  // ==========================================================================
  // Pointer word decoding
  function automatic logic psru_bcd_valid(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < PSRU_DIGITS; i++) begin
      if (v[i*4 +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : psru_bcd_valid

  function automatic logic [13:0] psru_bcd_to_bin(input logic [15:0] v);
    return 14'(v[15:12]) * 14'h3e8 + 14'(v[11:8]) * 14'h64 + 14'(v[7:4]) * 14'ha + 14'(v[3:0]);
  endfunction : psru_bcd_to_bin

endpackage : psru_pkg

// file: rtl/psru_shift_rotate_unit.sv
// Shift and rotate execution unit of the controller
// Overview of operation
// (RQ1) Edge shift inserts input bit at bottom on rising pulse with clear off.
// (RQ2) Inserting moves all bits toward MSB; top bit of end word lost.
// (RQ3) Pulse unchanged or falling leaves edge shift register untouched.
// (RQ4) Start word is lowest, end word highest; all words between included.
// (RQ5) Edge clear forces all register bits to zero, no shifting meanwhile.
// (RQ6) Edge shift leaves carry, equality and error flags unchanged.
// (RQ7) Issuer keeps start and end in one area, end not below start.
// (RQ8) Control word: bit 12 direction, 13 insert, 14 pulse, 15 clear.
// (RQ9) Reversible shift with condition and pulse: outgoing bit to carry.
// (RQ10) Condition off or pulse bit clear keeps reversible register unchanged.
// (RQ11) Condition on with clear bit zeroes register and carry.
// (RQ12) Reversible: error if areas differ or start above end.
// (RQ13) Carry takes start bit 00 or end bit 15, per direction.
// (RQ14) Indirect pointer not BCD or beyond data memory sets error.
// (RQ15) Arithmetic left: zero into bit 00, old bit 15 to carry.
// (RQ16) Arithmetic right: zero into bit 15, old bit 00 to carry.
// (RQ17) Single-word ops with condition off change nothing.
// (RQ18) Rotate left moves bits up; old bit 15 into carry.
// (RQ19) Rotate left puts prior carry into bit 00.
// (RQ20) Single-word ops set equality flag when result is zero.
// (RQ21) Issuer sets or clears carry before rotating.
`timescale 1ns/1ps
module psru_shift_rotate_unit #(
  parameter int DM_WORDS = 256,
  parameter int ID_W     = 4
) (
  // Clock and reset
  input  wire logic                            clk_sys_i,
  input  wire logic                            rst_i,
  // Operation request
  input  wire logic                            op_valid_i,
  output logic                                 op_ready_o,
  input  wire psru_pkg::psru_op_e              op_i,
  input  wire logic                            exec_cond_i,
  input  wire logic                            shift_in_i,
  input  wire logic                            pulse_cond_i,
  input  wire logic                            clear_cond_i,
  input  wire logic [ID_W-1:0]                 inst_id_i,
  input  wire logic [psru_pkg::PSRU_WORD_W-1:0] ctrl_word_i,
  input  wire logic [psru_pkg::PSRU_AREA_W-1:0] start_area_i,
  input  wire logic [psru_pkg::PSRU_OFF_W-1:0]  start_off_i,
  input  wire logic                            start_ind_i,
  input  wire logic [psru_pkg::PSRU_AREA_W-1:0] end_area_i,
  input  wire logic [psru_pkg::PSRU_OFF_W-1:0]  end_off_i,
  input  wire logic                            end_ind_i,
  output logic                                 op_done_o,
  // Carry set and clear
  input  wire logic                            set_carry_i,
  input  wire logic                            clear_carry_i,
  // Memory access while idle
  input  wire logic                            mem_we_i,
  input  wire logic [psru_pkg::PSRU_AW-1:0]    mem_addr_i,
  input  wire logic [psru_pkg::PSRU_WORD_W-1:0] mem_wdata_i,
  output logic      [psru_pkg::PSRU_WORD_W-1:0] mem_rdata_o,
  // Flags
  output logic                                 carry_flag_o,
  output logic                                 equal_zero_flag_o,
  output logic                                 operand_error_flag_o
);
  import psru_pkg::*;

  localparam logic [13:0] DM_LIMIT = 14'(DM_WORDS);

  typedef enum logic [2:0] {
    ST_IDLE, ST_PTR_RD, ST_PTR_CHK, ST_CHECK, ST_WORD_RD, ST_WORD_WR, ST_FIN
  } psru_state_e;

  psru_state_e            state_reg, state_next;
  psru_op_e               op_reg, op_next;
  logic [PSRU_AREA_W-1:0] s_area_reg, s_area_next, e_area_reg, e_area_next;
  logic [PSRU_OFF_W-1:0]  s_off_reg, s_off_next, e_off_reg, e_off_next;
  logic [PSRU_OFF_W-1:0]  cur_off_reg, cur_off_next;
  logic                   e_ind_reg, e_ind_next, ptr_sel_reg, ptr_sel_next;
  logic                   ptr_err_reg, ptr_err_next;
  logic                   cond_reg, cond_next, in_bit_reg, in_bit_next;
  logic                   clr_in_reg, clr_in_next, rising_reg, rising_next;
  logic [PSRU_WORD_W-1:0] ctrl_reg, ctrl_next;
  logic                   clear_reg, clear_next, left_reg, left_next;
  logic                   chain_reg, chain_next, zero_reg, zero_next;
  logic                   upd_cy_reg, upd_cy_next, upd_eq_reg, upd_eq_next;
  logic                   carry_reg, carry_next, eq_reg, eq_next, er_reg, er_next;
  logic                   done_reg, done_next;
  logic [2**ID_W-1:0]     prev_pulse_reg, prev_pulse_next;

  logic                   int_we, range_bad, busy;
  logic [PSRU_AW-1:0]     int_addr;
  logic [PSRU_WORD_W-1:0] rd_data, sh_word, int_wdata;
  logic                   sh_out;
  logic [13:0]            ptr_bin;

  // ==========================================================================
  // Datapath pieces
  psru_word_mem #(
    .AW (PSRU_AW),
    .DW (PSRU_WORD_W)
  ) u_mem (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .we_i      (busy ? int_we : mem_we_i),
    .addr_i    (busy ? int_addr : mem_addr_i),
    .wdata_i   (busy ? int_wdata : mem_wdata_i),
    .rdata_o   (rd_data)
  );

  psru_bit_shift u_shift (
    .word_i (rd_data),
    .left_i (left_reg),
    .ins_i  (chain_reg),
    .word_o (sh_word),
    .out_o  (sh_out)
  );

  assign busy      = (state_reg != ST_IDLE);
  assign ptr_bin   = psru_bcd_to_bin(rd_data);
  // (RQ5) Clear writes zeros
  assign int_wdata = clear_reg ? PSRU_WORD_ZERO : sh_word;
  assign range_bad = (s_area_reg != e_area_reg) || (s_off_reg > e_off_reg);

  // ==========================================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;    op_next = op_reg;
    s_area_next = s_area_reg;  e_area_next = e_area_reg;
    s_off_next = s_off_reg;    e_off_next = e_off_reg;
    cur_off_next = cur_off_reg;
    e_ind_next = e_ind_reg;    ptr_sel_next = ptr_sel_reg;  ptr_err_next = ptr_err_reg;
    cond_next = cond_reg;      in_bit_next = in_bit_reg;
    clr_in_next = clr_in_reg;  rising_next = rising_reg;    ctrl_next = ctrl_reg;
    clear_next = clear_reg;    left_next = left_reg;
    chain_next = chain_reg;    zero_next = zero_reg;
    upd_cy_next = upd_cy_reg;  upd_eq_next = upd_eq_reg;
    carry_next = carry_reg;    eq_next = eq_reg;            er_next = er_reg;
    prev_pulse_next = prev_pulse_reg;
    done_next = 1'b0;
    int_we = 1'b0;
    int_addr = {s_area_reg, cur_off_reg};
    case (state_reg)
      ST_IDLE: begin
        if (op_valid_i) begin
          op_next = op_i;           cond_next = exec_cond_i;
          in_bit_next = shift_in_i; clr_in_next = clear_cond_i;
          ctrl_next = ctrl_word_i;
          s_area_next = start_area_i; s_off_next = start_off_i;
          e_area_next = end_area_i;   e_off_next = end_off_i;
          e_ind_next = end_ind_i;     ptr_err_next = 1'b0;
          clear_next = 1'b0;          upd_cy_next = 1'b0;  upd_eq_next = 1'b0;
          // (RQ1) Rising pulse against last execution
          rising_next = pulse_cond_i & ~prev_pulse_reg[inst_id_i];
          if (op_i == OP_EDGE_SHIFT) begin
            prev_pulse_next[inst_id_i] = pulse_cond_i;
          end
          ptr_sel_next = ~start_ind_i;
          state_next = (start_ind_i || end_ind_i) ? ST_PTR_RD : ST_CHECK;
        end else if (set_carry_i) begin
          carry_next = 1'b1;
        end else if (clear_carry_i) begin
          carry_next = 1'b0;
        end
      end
      ST_PTR_RD: begin
        int_addr = {PSRU_DM_AREA, ptr_sel_reg ? e_off_reg : s_off_reg};
        state_next = ST_PTR_CHK;
      end
      ST_PTR_CHK: begin
        state_next = ST_CHECK;
        // (RQ14) Pointer must be BCD inside data memory
        if (!psru_bcd_valid(rd_data) || ptr_bin >= DM_LIMIT) begin
          ptr_err_next = 1'b1;
        end else if (ptr_sel_reg) begin
          e_area_next = PSRU_DM_AREA;
          e_off_next = ptr_bin[PSRU_OFF_W-1:0];
        end else begin
          s_area_next = PSRU_DM_AREA;
          s_off_next = ptr_bin[PSRU_OFF_W-1:0];
          if (e_ind_reg) begin
            ptr_sel_next = 1'b1;
            state_next = ST_PTR_RD;
          end
        end
      end
      ST_CHECK: begin
        state_next = ST_FIN;
        case (op_reg)
          OP_EDGE_SHIFT: begin
            // (RQ6) Flags untouched; bad operands skip silently
            if (!(ptr_err_reg || range_bad)) begin
              // (RQ5) Clear dominates shifting
              if (clr_in_reg) begin
                clear_next = 1'b1;
                // Walk upward, else a stale right shift stops at the start word
                left_next = 1'b1;
                state_next = ST_WORD_RD;
              // (RQ1) Shift only on rising pulse, (RQ3) else hold
              end else if (rising_reg) begin
                left_next = 1'b1;
                chain_next = in_bit_reg;
                state_next = ST_WORD_RD;
              end
              // (RQ4) Walk from start word up to end word
              cur_off_next = s_off_reg;
            end
          end
          OP_REV_SHIFT: begin
            // (RQ10) Condition off changes nothing
            if (cond_reg) begin
              // (RQ12) Range check, (RQ14) pointer error
              if (ptr_err_reg || range_bad) begin
                er_next = 1'b1;
              end else begin
                er_next = 1'b0;
                // (RQ11) Clear bit zeroes register and carry
                if (ctrl_reg[PSRU_RV_CLR_BIT]) begin
                  clear_next = 1'b1;
                  left_next = 1'b1;
                  chain_next = 1'b0;
                  upd_cy_next = 1'b1;
                  cur_off_next = s_off_reg;
                  state_next = ST_WORD_RD;
                // (RQ8) Control word fields, (RQ9) shift one place
                end else if (ctrl_reg[PSRU_RV_PULSE_BIT]) begin
                  left_next = ctrl_reg[PSRU_RV_DIR_BIT];
                  chain_next = ctrl_reg[PSRU_RV_INS_BIT];
                  upd_cy_next = 1'b1;
                  cur_off_next = ctrl_reg[PSRU_RV_DIR_BIT] ? s_off_reg : e_off_reg;
                  state_next = ST_WORD_RD;
                end
              end
            end
          end
          default: begin
            // (RQ17) Condition off: word and flags kept
            if (cond_reg) begin
              if (ptr_err_reg) begin
                er_next = 1'b1;
              end else begin
                er_next = 1'b0;
                e_area_next = s_area_reg;
                e_off_next = s_off_reg;
                cur_off_next = s_off_reg;
                // (RQ15) (RQ16) Zero enters; (RQ19) rotate brings carry in
                left_next = (op_reg != OP_ASR);
                chain_next = (op_reg == OP_ROL) ? carry_reg : 1'b0;
                upd_cy_next = 1'b1;
                upd_eq_next = 1'b1;
                state_next = ST_WORD_RD;
              end
            end
          end
        endcase
      end
      ST_WORD_RD: begin
        state_next = ST_WORD_WR;
      end
      ST_WORD_WR: begin
        int_we = 1'b1;
        // (RQ2) Ejected bit feeds the next word in line
        chain_next = clear_reg ? 1'b0 : sh_out;
        zero_next = (int_wdata == PSRU_WORD_ZERO);
        if (cur_off_reg == (left_reg ? e_off_reg : s_off_reg)) begin
          state_next = ST_FIN;
        end else begin
          cur_off_next = left_reg ? cur_off_reg + 1'b1 : cur_off_reg - 1'b1;
          state_next = ST_WORD_RD;
        end
      end
      ST_FIN: begin
        // (RQ13) (RQ18) Last ejected bit lands in carry
        if (upd_cy_reg) begin
          carry_next = chain_reg;
        end
        // (RQ20) Equality follows the result word
        if (upd_eq_reg) begin
          eq_next = zero_reg;
        end
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;   op_reg <= OP_EDGE_SHIFT;
      s_area_reg <= '0;       e_area_reg <= '0;
      s_off_reg <= '0;        e_off_reg <= '0;    cur_off_reg <= '0;
      e_ind_reg <= 1'b0;      ptr_sel_reg <= 1'b0; ptr_err_reg <= 1'b0;
      cond_reg <= 1'b0;       in_bit_reg <= 1'b0;
      clr_in_reg <= 1'b0;     rising_reg <= 1'b0;  ctrl_reg <= '0;
      clear_reg <= 1'b0;      left_reg <= 1'b0;
      chain_reg <= 1'b0;      zero_reg <= 1'b0;
      upd_cy_reg <= 1'b0;     upd_eq_reg <= 1'b0;
      carry_reg <= 1'b0;      eq_reg <= 1'b0;      er_reg <= 1'b0;
      done_reg <= 1'b0;       prev_pulse_reg <= '0;
    end else begin
      state_reg <= state_next; op_reg <= op_next;
      s_area_reg <= s_area_next; e_area_reg <= e_area_next;
      s_off_reg <= s_off_next;   e_off_reg <= e_off_next;  cur_off_reg <= cur_off_next;
      e_ind_reg <= e_ind_next;   ptr_sel_reg <= ptr_sel_next; ptr_err_reg <= ptr_err_next;
      cond_reg <= cond_next;     in_bit_reg <= in_bit_next;
      clr_in_reg <= clr_in_next; rising_reg <= rising_next; ctrl_reg <= ctrl_next;
      clear_reg <= clear_next;   left_reg <= left_next;
      chain_reg <= chain_next;   zero_reg <= zero_next;
      upd_cy_reg <= upd_cy_next; upd_eq_reg <= upd_eq_next;
      carry_reg <= carry_next;   eq_reg <= eq_next;        er_reg <= er_next;
      done_reg <= done_next;     prev_pulse_reg <= prev_pulse_next;
    end
  end

  assign op_ready_o           = ~busy;
  assign op_done_o            = done_reg;
  assign mem_rdata_o          = rd_data;
  assign carry_flag_o         = carry_reg;
  assign equal_zero_flag_o    = eq_reg;
  assign operand_error_flag_o = er_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence edge_fin_s;
    state_reg == ST_FIN && op_reg == OP_EDGE_SHIFT;
  endsequence
  sequence quiet_req_s;
    op_valid_i && op_ready_o && op_i != OP_EDGE_SHIFT && op_i != OP_REV_SHIFT && !exec_cond_i;
  endsequence
  sequence edge_hold_s;
    op_valid_i && op_ready_o && op_i == OP_EDGE_SHIFT && !clear_cond_i
      && !(pulse_cond_i && !prev_pulse_reg[inst_id_i]);
  endsequence

  edge_flags_hold_a: assert property (edge_fin_s |=> $stable(carry_reg) && $stable(eq_reg) && $stable(er_reg)) // RQ6
    else $error("edge shift changed a flag");
  edge_no_shift_a: assert property (edge_hold_s |=> (!int_we)[*3]) // RQ3
    else $error("edge shift wrote without rising pulse");
  clear_zero_a: assert property (state_reg == ST_WORD_WR && clear_reg |-> u_mem.wdata_i == PSRU_WORD_ZERO && left_reg) // RQ5
    else $error("clear wrote nonzero data");
  chain_left_a: assert property (state_reg == ST_WORD_WR && left_reg && !clear_reg
    |-> int_wdata[PSRU_LSB] == chain_reg ##1 chain_reg == $past(rd_data[PSRU_MSB])) // RQ2
    else $error("left chain bit wrong");
  asr_carry_a: assert property (state_reg == ST_WORD_WR && op_reg == OP_ASR
    |-> int_wdata[PSRU_MSB] == 1'b0 ##2 carry_reg == $past(rd_data[PSRU_LSB], 2)) // RQ16
    else $error("right shift carry wrong");
  rol_carry_in_a: assert property (state_reg == ST_CHECK && op_reg == OP_ROL && cond_reg && !ptr_err_reg
    |-> ##2 int_wdata[PSRU_LSB] == $past(carry_reg, 2)) // RQ19
    else $error("rotate did not take prior carry");
  equal_flag_a: assert property (state_reg == ST_WORD_WR && upd_eq_reg
    |-> ##2 eq_reg == ($past(int_wdata, 2) == PSRU_WORD_ZERO)) // RQ20
    else $error("equality flag wrong");
  cond_off_a: assert property (quiet_req_s |=> (!int_we && $stable(carry_reg) && $stable(eq_reg))[*2]) // RQ17
    else $error("single-word op acted with condition off");
  rev_error_a: assert property (state_reg == ST_CHECK && op_reg == OP_REV_SHIFT && cond_reg && range_bad
    |=> er_reg ##1 done_reg) // RQ12
    else $error("bad range not flagged");
  rev_clear_a: assert property (state_reg == ST_FIN && op_reg == OP_REV_SHIFT && clear_reg |=> !carry_reg) // RQ11
    else $error("reversible clear left carry set");

endmodule : psru_shift_rotate_unit

// file: rtl/psru_word_mem.sv
// Word memory holding the operand areas, registered read data
`timescale 1ns/1ps
module psru_word_mem #(
  parameter int AW = 11,
  parameter int DW = 16
) (
  // Clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  // Access port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_reg [2**AW];
  logic [DW-1:0] rdata_reg;

  // ==========================================================================
  // Storage; read returns the old word on a same-cycle write
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_reg[addr_i] <= wdata_i;
    end
    if (rst_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= mem_reg[addr_i];
    end
  end

  assign rdata_o = rdata_reg;

endmodule : psru_word_mem

// file: verification/psru_scan_seq.sv
// Scan sequencer model that issues shift operations
`timescale 1ns/1ps
module psru_scan_seq
  import psru_pkg::*;
(
  // Clock and handshake
  input  wire logic  clk_i,
  input  wire logic  op_ready_i,
  // Request fields
  output logic       op_valid_o,
  output psru_op_e   op_o,
  output logic       cond_o,
  output logic       pulse_o,
  output logic       clear_o,
  output logic       shift_in_o,
  output logic [15:0] ctrl_o,
  output logic [2:0] end_area_o,
  output logic [7:0] start_off_o,
  output logic [7:0] end_off_o,
  output logic       stuck_o
);
  initial begin
    {op_valid_o, cond_o, pulse_o, clear_o, shift_in_o, stuck_o} = '0;
    op_o = OP_ASL;
    {ctrl_o, end_area_o, start_off_o, end_off_o} = {16'h0, 3'h1, 8'h0, 8'h0};
  end
  // range legal unless the caller breaks it on purpose
  task automatic issue(input psru_op_e op, input logic c, p, r, i, input logic [15:0] cw,
                       input logic [2:0] ea, input logic [7:0] so, eo);
    int n;
    op_o <= op;
    {op_valid_o, cond_o, pulse_o, clear_o, shift_in_o} <= {1'b1, c, p, r, i};
    {ctrl_o, end_area_o, start_off_o, end_off_o} <= {cw, ea, so, eo};
    for (n = 0; n < 50 && op_ready_i !== 1'b1; n++) @(negedge clk_i);
    stuck_o <= (n == 50);
    @(negedge clk_i);
    op_valid_o <= 1'b0;
    // Released fields must not keep showing the request
    {ctrl_o, shift_in_o} <= {~cw, ~i};
  endtask : issue
endmodule : psru_scan_seq

// file: verification/psru_shift_rotate_unit_bench.sv
// Self-checking bench for the shift and rotate unit
`timescale 1ns/1ps
module psru_shift_rotate_unit_bench;
  import psru_pkg::*;
  logic clk_sys_i, rst_i, op_ready_o, op_done_o, set_carry_i, clear_carry_i, mem_we_i;
  logic carry_flag_o, equal_zero_flag_o, operand_error_flag_o;
  logic op_valid, cond, pulse, clr, sin, stuck, ind;
  logic [10:0] mem_addr_i;
  logic [15:0] mem_wdata_i, mem_rdata_o, ctrl, w, x, r;
  logic [7:0] so, eo;
  logic [2:0] ea, fl;
  logic [2:0] q[$];
  psru_op_e op;
  int miscompares, num_checks, k;

  psru_shift_rotate_unit u_psru_shift_rotate_unit (
    .clk_sys_i, .rst_i, .op_valid_i(op_valid), .op_ready_o, .op_i(op), .exec_cond_i(cond),
    .shift_in_i(sin), .pulse_cond_i(pulse), .clear_cond_i(clr), .inst_id_i(4'h0), .ctrl_word_i(ctrl),
    .start_area_i(3'h1), .start_off_i(so), .start_ind_i(ind), .end_area_i(ea), .end_off_i(eo),
    .end_ind_i(1'b0), .op_done_o, .set_carry_i, .clear_carry_i, .mem_we_i, .mem_addr_i,
    .mem_wdata_i, .mem_rdata_o, .carry_flag_o, .equal_zero_flag_o, .operand_error_flag_o);
  psru_scan_seq u_psru_scan_seq (
    .clk_i(clk_sys_i), .op_ready_i(op_ready_o), .op_valid_o(op_valid), .op_o(op), .cond_o(cond),
    .pulse_o(pulse), .clear_o(clr), .shift_in_o(sin), .ctrl_o(ctrl), .end_area_o(ea),
    .start_off_o(so), .end_off_o(eo), .stuck_o(stuck));

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic mw(input logic [7:0] a, input logic [15:0] d, input logic [2:0] ar = 3'h1);
    {mem_addr_i, mem_wdata_i, mem_we_i} <= {ar, a, d, 1'b1};
    @(negedge clk_sys_i);
    mem_we_i <= 1'b0;
    // Idle edge so a following write does not re-drive the strobe in this step
    @(negedge clk_sys_i);
  endtask : mw
  task automatic mr(input logic [7:0] a, input logic [15:0] e, input logic [2:0] ar = 3'h1);
    mem_addr_i <= {ar, a};
    @(negedge clk_sys_i);
    chk(mem_rdata_o, e);
  endtask : mr
  // Expected flags are noted before the request goes out
  task automatic run(input psru_op_e o, input logic c, p, rr, i, input logic [15:0] cw,
                     input logic [2:0] a, input logic [7:0] s, e);
    int n;
    q.push_back(fl);
    u_psru_scan_seq.issue(o, c, p, rr, i, cw, a, s, e);
    for (n = 0; n < 60 && op_done_o !== 1'b1; n++) @(negedge clk_sys_i);
    if (n == 60 || stuck) begin
      miscompares++;
      end_of_test();
    end else begin
      @(negedge clk_sys_i);
    end
  endtask : run

  always @(negedge clk_sys_i) begin
    if (op_done_o === 1'b1) begin
      if (q.size() == 0) chk(16'hffff, 16'h0000);
      else chk({13'h0, carry_flag_o, equal_zero_flag_o, operand_error_flag_o}, {13'h0, q.pop_front()});
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {rst_i, ind, set_carry_i, clear_carry_i, mem_we_i, mem_addr_i, mem_wdata_i} = {2'b10, 3'h0, 11'h0, 16'h0};
    {fl, w} = {3'h0, 16'h004e};
    repeat (8) @(negedge clk_sys_i);
    rst_i <= 1'b0;
    for (k = 0; k < 4; k++) begin
      w = lfsr(w);
      x = (k == 2) ? 16'h8000 : (k == 3) ? 16'h0001 : w;
      r = k[0] ? x >> 1 : x << 1;
      fl = {k[0] ? x[0] : x[15], r == 16'h0000, 1'b0};
      mw(8'h01, x);
      run(k[0] ? OP_ASR : OP_ASL, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 3'h1, 8'h01, 8'h01);
      mr(8'h01, r);
    end
    mw(8'h01, w);
    run(OP_ASL, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 3'h1, 8'h01, 8'h01);
    mr(8'h01, w);
    for (k = 0; k < 2; k++) begin
      {set_carry_i, clear_carry_i} <= {~k[0], k[0]};
      @(negedge clk_sys_i);
      {set_carry_i, clear_carry_i} <= 2'b00;
      w = lfsr(w);
      r = {w[14:0], ~k[0]};
      fl = {w[15], r == 16'h0000, 1'b0};
      mw(8'h02, w);
      run(OP_ROL, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 3'h1, 8'h02, 8'h02);
      mr(8'h02, r);
    end
    w = lfsr(w);
    x = lfsr(w);
    mw(8'h06, w);
    mw(8'h07, x);
    run(OP_EDGE_SHIFT, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0000, 3'h1, 8'h06, 8'h07);
    mr(8'h06, {w[14:0], 1'b1});
    mr(8'h07, {x[14:0], w[15]});
    run(OP_EDGE_SHIFT, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000, 3'h1, 8'h06, 8'h07);
    mr(8'h06, {w[14:0], 1'b1});
    run(OP_EDGE_SHIFT, 1'b0, 1'b1, 1'b1, 1'b1, 16'h0000, 3'h1, 8'h06, 8'h07);
    mr(8'h07, 16'h0000);
    mw(8'h08, x);
    mw(8'h09, w);
    fl = {w[15], fl[1], 1'b0};
    run(OP_REV_SHIFT, 1'b1, 1'b0, 1'b0, 1'b0, 16'h7000, 3'h1, 8'h08, 8'h09);
    mr(8'h08, {x[14:0], 1'b1});
    mr(8'h09, {w[14:0], x[15]});
    fl = {1'b1, fl[1], 1'b0};
    run(OP_REV_SHIFT, 1'b1, 1'b0, 1'b0, 1'b0, 16'h4000, 3'h1, 8'h08, 8'h09);
    mr(8'h08, x);
    mr(8'h09, {1'b0, w[14:0]});
    run(OP_REV_SHIFT, 1'b0, 1'b0, 1'b0, 1'b0, 16'h7000, 3'h1, 8'h08, 8'h09);
    mr(8'h08, x);
    fl = {1'b0, fl[1], 1'b0};
    run(OP_REV_SHIFT, 1'b1, 1'b0, 1'b0, 1'b0, 16'hc000, 3'h1, 8'h08, 8'h09);
    mr(8'h09, 16'h0000);
    fl[0] = 1'b1;
    run(OP_REV_SHIFT, 1'b1, 1'b0, 1'b0, 1'b0, 16'h4000, 3'h1, 8'h09, 8'h08);
    run(OP_REV_SHIFT, 1'b1, 1'b0, 1'b0, 1'b0, 16'h4000, 3'h2, 8'h08, 8'h09);
    // Indirect start word: BCD pointer 0010 selects data memory word 0a
    ind <= 1'b1;
    mw(8'h05, 16'h0010, PSRU_DM_AREA);
    mw(8'h0a, w, PSRU_DM_AREA);
    fl = {w[15], w[14:0] == 15'h0, 1'b0};
    run(OP_ASL, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 3'h1, 8'h05, 8'h05);
    mr(8'h0a, {w[14:0], 1'b0}, PSRU_DM_AREA);
    mw(8'h05, 16'h00a0, PSRU_DM_AREA);
    fl[0] = 1'b1;
    run(OP_ASL, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 3'h1, 8'h05, 8'h05);
    mr(8'h0a, {w[14:0], 1'b0}, PSRU_DM_AREA);
    ind <= 1'b0;
    // Edge clear right after a right shift must still reach the end word
    mw(8'h09, w);
    fl = 3'b010;
    run(OP_ASR, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 3'h1, 8'h08, 8'h08);
    run(OP_EDGE_SHIFT, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, 3'h1, 8'h08, 8'h09);
    mr(8'h09, 16'h0000);
    end_of_test();
  end
endmodule : psru_shift_rotate_unit_bench
